// ### rtl/v110_rx_descriptor_ring.sv
// receive descriptor ring engine for the rate-adaptation receiver
//
// Notes on behaviour
// - host sets bit 15 to lend a buffer; engine clears it when done
// - bit 15 cleared when buffer full or reception aborted by error
// - bit 15 stays set while the buffer is still being filled
// - bit 14 clear writes inner RAM, bit 14 set writes outer memory
// - wrap bit set: continue at the first descriptor of the ring
// - nonzero octet with top bit clear flags a sync error
// - receive overrun during a message sets the overrun flag
// - host writes bits 15 to 13; engine sets bits 1 and 3 at close
// - status bits 12 to 4, 2 and 0 carry no meaning here
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module v110_rx_descriptor_ring (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic mem_ext,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);

  typedef enum logic [2:0] {
    S_OFF,
    S_RD_CTL,
    S_POLL,
    S_RD_HI,
    S_RD_LO,
    S_FILL,
    S_WR_LEN,
    S_WR_CTL
  } state_e;

  state_e state_q;
  logic [v110_rx_pkg::IDX_W-1:0] idx_q;
  logic [15:0] ctl_q;
  logic [15:0] cnt_q;
  logic [23:0] ptr_q;
  logic pend_q;
  logic pend_last_q;
  logic [7:0] pend_data_q;
  logic ovr_buf_q;
  logic [4:0] poll_q;
  logic en_q;
  logic [15:0] base_q;
  logic [15:0] maxlen_q;
  logic [v110_rx_pkg::EV_W-1:0] ev_q;
  logic [v110_rx_pkg::EV_W-1:0] mask_q;
  logic [v110_rx_pkg::EV_W-1:0] ev_set;

  logic acc_ack;
  logic byte_ok;
  logic fill_wr;
  logic need;
  logic overrun;
  logic take;
  logic start;
  logic buf_end;
  logic sync_hit;
  logic buf_sync;
  logic [15:0] bd_base;
  logic [15:0] cnt_inc;
  logic wr_d;
  logic [23:0] addr_d;
  logic [15:0] wdata_d;

  assign acc_ack = mem_req && mem_ack;
  assign byte_ok = acc_ack && (state_q == S_FILL);
  assign fill_wr = (state_q == S_FILL) && pend_q && !ovr_buf_q;
  assign need = fill_wr || (state_q == S_RD_CTL) || (state_q == S_RD_HI)
    || (state_q == S_RD_LO) || (state_q == S_WR_LEN) || (state_q == S_WR_CTL);
  // no buffer behind the holding byte: a second octet while one waits is lost
  assign overrun = en_q && rx_valid && pend_q && !byte_ok;
  assign take = en_q && rx_valid && !(pend_q && !byte_ok);
  assign start = acc_ack && (state_q == S_RD_CTL) && mem_rdata[v110_rx_pkg::BD_EMPTY];
  assign bd_base = base_q + 16'({idx_q, 3'b000});
  assign cnt_inc = cnt_q + 16'h0001;
  assign buf_end = pend_last_q || (cnt_inc >= maxlen_q) || ovr_buf_q || overrun;

  v110_octet_check u_chk (
    .mclk(mclk),
    .reset(reset),
    .clr(start),
    .byte_valid(byte_ok),
    .byte_data(pend_data_q),
    .bad(sync_hit),
    .seen_q(buf_sync)
  );

  // access fields for the current state
  always_comb begin
    wr_d = 1'b1;
    addr_d = 24'h000000;
    wdata_d = 16'h0000;
    unique case (state_q)
      S_RD_CTL: begin
        wr_d = 1'b0;
        addr_d = {8'h00, bd_base};
      end
      S_RD_HI: begin
        wr_d = 1'b0;
        addr_d = {8'h00, bd_base + v110_rx_pkg::BD_PTRH_OFF};
      end
      S_RD_LO: begin
        wr_d = 1'b0;
        addr_d = {8'h00, bd_base + v110_rx_pkg::BD_PTRL_OFF};
      end
      S_FILL: begin
        addr_d = ptr_q + {8'h00, cnt_q};
        wdata_d = {8'h00, pend_data_q};
      end
      S_WR_LEN: begin
        addr_d = {8'h00, bd_base + v110_rx_pkg::BD_LEN_OFF};
        wdata_d = cnt_q;
      end
      S_WR_CTL: begin
        addr_d = {8'h00, bd_base};
        wdata_d = ctl_q;
        wdata_d[v110_rx_pkg::BD_EMPTY] = 1'b0;
        wdata_d[v110_rx_pkg::BD_SYNC] = buf_sync;
        wdata_d[v110_rx_pkg::BD_OVR] = ovr_buf_q;
      end
      S_OFF, S_POLL: begin
        wr_d = 1'b0;
      end
    endcase
  end

  // memory request: fields held from issue until acknowledge
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_ext <= 1'b0;
      mem_addr <= 24'h000000;
      mem_wdata <= 16'h0000;
    end else if (acc_ack) begin
      mem_req <= 1'b0;
    end else if (!mem_req && need) begin
      mem_req <= 1'b1;
      mem_we <= wr_d;
      mem_byte <= (state_q == S_FILL);
      mem_ext <= (state_q == S_FILL) && ctl_q[v110_rx_pkg::BD_EXT];
      mem_addr <= addr_d;
      mem_wdata <= wdata_d;
    end
  end

  // descriptor walk
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= S_OFF;
      idx_q <= '0;
      ctl_q <= 16'h0000;
      ptr_q <= 24'h000000;
      cnt_q <= 16'h0000;
      poll_q <= 5'h00;
    end else begin
      unique case (state_q)
        S_OFF: begin
          idx_q <= '0;
          if (en_q) begin
            state_q <= S_RD_CTL;
          end
        end
        S_RD_CTL: begin
          if (acc_ack) begin
            ctl_q <= mem_rdata;
            poll_q <= 5'h00;
            state_q <= start ? S_RD_HI : S_POLL;
          end
        end
        S_POLL: begin
          poll_q <= poll_q + 5'h01;
          if (!en_q) begin
            state_q <= S_OFF;
          end else if (poll_q == v110_rx_pkg::POLL_CYC - 5'h01) begin
            state_q <= S_RD_CTL;
          end
        end
        S_RD_HI: begin
          if (acc_ack) begin
            ptr_q[23:16] <= mem_rdata[7:0];
            state_q <= S_RD_LO;
          end
        end
        S_RD_LO: begin
          if (acc_ack) begin
            ptr_q[15:0] <= mem_rdata;
            cnt_q <= 16'h0000;
            state_q <= S_FILL;
          end
        end
        S_FILL: begin
          if (byte_ok) begin
            cnt_q <= cnt_inc;
            if (buf_end) begin
              state_q <= S_WR_LEN;
            end
          end else if (!mem_req && ovr_buf_q) begin
            state_q <= S_WR_LEN;
          end
        end
        S_WR_LEN: begin
          if (acc_ack) begin
            state_q <= S_WR_CTL;
          end
        end
        S_WR_CTL: begin
          if (acc_ack) begin
            if (ctl_q[v110_rx_pkg::BD_WRAP]) begin
              idx_q <= '0;
            end else begin
              // next in turn; ring never longer than eight
              idx_q <= idx_q + 1'b1;
            end
            state_q <= S_RD_CTL;
          end
        end
      endcase
    end
  end

  // holding byte between receiver and memory
  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_q <= 1'b0;
      pend_last_q <= 1'b0;
      pend_data_q <= 8'h00;
    end else if (take) begin
      pend_q <= 1'b1;
      pend_last_q <= rx_last;
      pend_data_q <= rx_data;
    end else if (byte_ok) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ovr_buf_q <= 1'b0;
    end else if (overrun && (state_q == S_RD_HI || state_q == S_RD_LO
        || state_q == S_FILL)) begin
      ovr_buf_q <= 1'b1;
    end else if (start) begin
      ovr_buf_q <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      en_q <= 1'b0;
      base_q <= v110_rx_pkg::BASE_RST;
      maxlen_q <= v110_rx_pkg::MAXLEN_RST;
      mask_q <= v110_rx_pkg::MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == v110_rx_pkg::REG_CTRL) begin
        en_q <= reg_wdata[0];
      end
      if (reg_addr == v110_rx_pkg::REG_BASE) begin
        base_q <= reg_wdata;
      end
      if (reg_addr == v110_rx_pkg::REG_MAXLEN) begin
        maxlen_q <= reg_wdata;
      end
      if (reg_addr == v110_rx_pkg::REG_MASK) begin
        mask_q <= reg_wdata[v110_rx_pkg::EV_W-1:0];
      end
    end
  end

  // sticky events, cleared by reading; a new event beats the clear
  always_comb begin
    ev_set = '0;
    ev_set[v110_rx_pkg::EV_CLOSE] = acc_ack && (state_q == S_WR_CTL);
    ev_set[v110_rx_pkg::EV_SYNC] = sync_hit;
    ev_set[v110_rx_pkg::EV_OVR] = overrun;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ev_q <= '0;
    end else if (reg_rd && reg_addr == v110_rx_pkg::REG_EVENT) begin
      ev_q <= ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end

  assign irq = |(ev_q & mask_q);

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        v110_rx_pkg::REG_CTRL: reg_rdata <= {15'h0000, en_q};
        v110_rx_pkg::REG_BASE: reg_rdata <= base_q;
        v110_rx_pkg::REG_MAXLEN: reg_rdata <= maxlen_q;
        v110_rx_pkg::REG_EVENT: reg_rdata <= {13'h0000, ev_q};
        v110_rx_pkg::REG_MASK: reg_rdata <= {13'h0000, mask_q};
        v110_rx_pkg::REG_STATE: reg_rdata <= {7'h00, pend_q,
          ovr_buf_q, 1'b0, state_q, idx_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_own_write;
    (mem_req && mem_we && !mem_byte && mem_addr == {8'h00, bd_base})
      |-> (state_q == S_WR_CTL) && !mem_wdata[v110_rx_pkg::BD_EMPTY];
  endproperty
  a_own_write: assert property (p_own_write) else $error("control word written early");

  property p_abort_close;
    (state_q == S_FILL && ovr_buf_q && !mem_req) |=> (state_q == S_WR_LEN);
  endproperty
  a_abort_close: assert property (p_abort_close) else $error("overrun did not close");

  property p_handback;
    (state_q == S_WR_LEN && acc_ack) |=> ##[1:2] (mem_req && mem_we
      && !mem_wdata[v110_rx_pkg::BD_EMPTY]);
  endproperty
  a_handback: assert property (p_handback) else $error("descriptor not returned");

  property p_location;
    (mem_req && mem_byte) |-> (mem_ext == ctl_q[v110_rx_pkg::BD_EXT]) && mem_we;
  endproperty
  a_location: assert property (p_location) else $error("wrong buffer memory");

  property p_wrap;
    (state_q == S_WR_CTL && acc_ack && ctl_q[v110_rx_pkg::BD_WRAP])
      |=> (idx_q == '0) && (state_q == S_RD_CTL);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not return to first");

  property p_step;
    (state_q == S_WR_CTL && acc_ack && !ctl_q[v110_rx_pkg::BD_WRAP])
      |=> (idx_q == $past(idx_q) + 1'b1);
  endproperty
  a_step: assert property (p_step) else $error("ring did not advance");

  property p_no_store_unlent;
    (mem_req && mem_byte) |-> ctl_q[v110_rx_pkg::BD_EMPTY];
  endproperty
  a_no_store_unlent: assert property (p_no_store_unlent) else $error("store without lend");

  property p_sync;
    sync_hit |=> buf_sync && ev_q[v110_rx_pkg::EV_SYNC];
  endproperty
  a_sync: assert property (p_sync) else $error("sync error not kept");

  property p_ovr;
    (overrun && state_q == S_FILL) |=> ovr_buf_q;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not kept");

  property p_status;
    (mem_req && state_q == S_WR_CTL) |-> mem_wdata[v110_rx_pkg::BD_SYNC] == buf_sync
      && mem_wdata[v110_rx_pkg::BD_OVR] == ovr_buf_q;
  endproperty
  a_status: assert property (p_status) else $error("close status wrong");

  property p_reserved;
    (mem_req && state_q == S_WR_CTL) |-> mem_wdata[12:4] == ctl_q[12:4]
      && mem_wdata[2] == ctl_q[2] && mem_wdata[0] == ctl_q[0];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits changed");

  c_close: cover property (state_q == S_WR_CTL && acc_ack);
  c_wrap: cover property (state_q == S_WR_CTL && acc_ack && ctl_q[v110_rx_pkg::BD_WRAP]);
  c_ovr: cover property (overrun && state_q == S_FILL);
  c_sync: cover property (sync_hit);

endmodule : v110_rx_descriptor_ring
`default_nettype wire

// ### rtl/v110_rx_pkg.sv
// constants for the receive descriptor ring engine
package v110_rx_pkg;
  // register offsets on the control port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_MAXLEN = 8'h08;
  localparam logic [7:0] REG_EVENT = 8'h0C;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;
  // reset values
  localparam logic [15:0] BASE_RST = 16'h0400;
  localparam logic [15:0] MAXLEN_RST = 16'h0010;
  localparam logic [2:0] MASK_RST = 3'h0;
  // descriptor control and status word
  localparam int BD_EMPTY = 15;
  localparam int BD_EXT = 14;
  localparam int BD_WRAP = 13;
  localparam int BD_SYNC = 3;
  localparam int BD_OVR = 1;
  // descriptor word offsets, eight bytes a descriptor
  localparam logic [15:0] BD_LEN_OFF = 16'h0002;
  localparam logic [15:0] BD_PTRH_OFF = 16'h0004;
  localparam logic [15:0] BD_PTRL_OFF = 16'h0006;
  localparam int BD_SHIFT = 3;
  localparam int IDX_W = 3;
  // event bits
  localparam int EV_CLOSE = 0;
  localparam int EV_SYNC = 1;
  localparam int EV_OVR = 2;
  localparam int EV_W = 3;
  // pause between two looks at a descriptor the host still holds
  localparam logic [4:0] POLL_CYC = 5'h10;
endpackage : v110_rx_pkg

// ### rtl/v110_octet_check.sv
// per-buffer octet synchronisation check
`timescale 1ns/10ps
`default_nettype none
module v110_octet_check (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clr,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic bad,
  output logic seen_q
);

  // zero octet is the frame sync pattern, exempt from the check
  assign bad = byte_valid && (byte_data != 8'h00) && !byte_data[7];

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      seen_q <= 1'b0;
    end else if (bad) begin
      seen_q <= 1'b1;
    end else if (clr) begin
      seen_q <= 1'b0;
    end
  end

endmodule : v110_octet_check
`default_nettype wire

// ### tb/v110_mem_model.sv
// memory partner: internal and external ram behind the engine's memory port
`timescale 1ns/10ps
`default_nettype none
module v110_mem_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic mem_ext,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  // top half external, bottom half internal dual-port ram
  logic [7:0] ram [0:8191];
  logic [3:0] wait_q;
  logic busy_q;
  logic [12:0] a;
  assign a = {mem_ext, mem_addr[11:0]};
  initial begin
    for (int i = 0; i < 8192; i++) begin
      ram[i] = 8'h00;
    end
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
  end
  // read data churns outside acks so a stale sample never matches
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (reset || !mem_req) begin
      wait_q <= 4'h0;
      busy_q <= 1'b0;
    end else if (!busy_q && wait_q < slow) begin
      wait_q <= wait_q + 4'h1;
    end else if (!busy_q) begin
      mem_ack <= 1'b1;
      busy_q <= 1'b1;
      if (!mem_we) begin
        mem_rdata <= {ram[a], ram[a + 13'h1]};
      end else if (mem_byte) begin
        ram[a] <= mem_wdata[7:0];
      end else begin
        ram[a] <= mem_wdata[15:8];
        ram[a + 13'h1] <= mem_wdata[7:0];
      end
    end
  end
endmodule : v110_mem_model
`default_nettype wire

// ### tb/v110_rx_descriptor_ring_bench.sv
// self-checking bench for the receive descriptor ring engine
`timescale 1ns/10ps
`default_nettype none
module v110_rx_descriptor_ring_bench;
  logic mclk, reset, reg_wr, reg_rd, irq, rx_valid, rx_last;
  logic mem_req, mem_we, mem_byte, mem_ext, mem_ack;
  logic [7:0] reg_addr, rx_data;
  logic [15:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata, got;
  logic [23:0] mem_addr;
  logic [3:0] slow;
  logic [7:0] fa [0:2] = '{8'h80, 8'h00, 8'h81};
  logic [7:0] fb [0:3] = '{8'h90, 8'h12, 8'h00, 8'hFF};
  int err_count, n_tests, cyc;

  v110_rx_descriptor_ring v110_rx_descriptor_ring_i (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
    .mem_ext(mem_ext), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  v110_mem_model v110_mem_model_i (.mclk(mclk), .reset(reset), .slow(slow),
    .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte), .mem_ext(mem_ext),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard, the whole run needs a few hundred cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (exp !== seen) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write

  task reg_check(input string what, input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask : reg_check

  function automatic logic [15:0] word(input logic ext, input logic [11:0] a);
    return {v110_mem_model_i.ram[{ext, a}], v110_mem_model_i.ram[{ext, a + 12'h1}]};
  endfunction : word

  // host side: whole descriptor written before it is lent
  task put_desc(input int idx, input logic [15:0] ctl, input logic [23:0] ptr);
    logic [15:0] w [0:3];
    w = '{ctl, 16'h0000, {8'h00, ptr[23:16]}, ptr[15:0]};
    for (int i = 0; i < 8; i++) begin
      v110_mem_model_i.ram[13'h400 + idx * 8 + i] = i[0] ? w[i / 2][7:0] : w[i / 2][15:8];
    end
  endtask : put_desc

  task send(input logic [7:0] d, input logic last);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_last <= last;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      if (mem_ack === 1'b1 && mem_byte === 1'b1) break;
    end
  endtask : send

  task wait_back(input int idx);
    for (int i = 0; i < 1000; i++) begin
      @(posedge mclk);
      if (v110_mem_model_i.ram[13'h400 + idx * 8][7] === 1'b0) break;
    end
    repeat (2) @(posedge mclk);
  endtask : wait_back

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    slow = 4'h0;
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    reg_check("base", v110_rx_pkg::REG_BASE, v110_rx_pkg::BASE_RST);
    reg_check("maxlen", v110_rx_pkg::REG_MAXLEN, v110_rx_pkg::MAXLEN_RST);
    reg_check("mask", v110_rx_pkg::REG_MASK, {13'h0000, v110_rx_pkg::MASK_RST});
    reg_check("event", v110_rx_pkg::REG_EVENT, 16'h0000);
    reg_check("unmapped", 8'h20, 16'h0000);
    reg_check("state", v110_rx_pkg::REG_STATE, 16'h0000);
    reg_write(v110_rx_pkg::REG_MAXLEN, 16'h0004);
    reg_check("maxlen", v110_rx_pkg::REG_MAXLEN, 16'h0004);
    put_desc(0, 16'h8000, 24'h000100);
    put_desc(1, 16'hC014, 24'h000200);
    put_desc(2, 16'hA000, 24'h000300);
    reg_write(v110_rx_pkg::REG_CTRL, 16'h0001);
    reg_check("ctrl", v110_rx_pkg::REG_CTRL, 16'h0001);
    send(fa[0], 1'b0);
    check("ctl0 filling", 16'h8000, word(1'b0, 12'h400));
    send(fa[1], 1'b0);
    send(fa[2], 1'b1);
    wait_back(0);
    for (int i = 0; i < 3; i++) begin
      check("buf0", {8'h00, fa[i]}, {8'h00, v110_mem_model_i.ram[13'h100 + i]});
    end
    check("ctl0 back", 16'h0000, word(1'b0, 12'h400));
    check("len0", 16'h0003, word(1'b0, 12'h402));
    check("irq masked", 16'h0000, {15'h0000, irq});
    reg_write(v110_rx_pkg::REG_MASK, 16'h0001);
    check("irq on", 16'h0001, {15'h0000, irq});
    reg_check("event", v110_rx_pkg::REG_EVENT, 16'h0001);
    check("irq off", 16'h0000, {15'h0000, irq});
    reg_write(v110_rx_pkg::REG_MASK, 16'h0007);
    // count closes this buffer; slow memory then lets the burst overrun
    for (int i = 0; i < 3; i++) begin
      send(fb[i], 1'b0);
    end
    slow <= 4'h6;
    send(fb[3], 1'b0);
    for (int i = 0; i < 1000; i++) begin
      @(posedge mclk);
      if (mem_ack === 1'b1 && mem_we === 1'b0 && mem_addr === 24'h000416) break;
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data <= 8'hC0 + 8'(i);
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    wait_back(2);
    for (int i = 0; i < 4; i++) begin
      check("buf1", {8'h00, fb[i]}, {8'h00, v110_mem_model_i.ram[13'h1200 + i]});
    end
    check("ctl1 back", 16'h401C, word(1'b0, 12'h408));
    check("len1", 16'h0004, word(1'b0, 12'h40A));
    check("ctl2 back", 16'h2002, word(1'b0, 12'h410));
    check("irq set", 16'h0001, {15'h0000, irq});
    reg_check("event", v110_rx_pkg::REG_EVENT, 16'h0007);
    // after the wrap the ring restarts at the first descriptor
    slow <= 4'h0;
    put_desc(0, 16'h8000, 24'h000180);
    send(8'hA5, 1'b1);
    wait_back(0);
    check("buf0 again", 16'h00A5, {8'h00, v110_mem_model_i.ram[13'h180]});
    check("ctl0 again", 16'h0000, word(1'b0, 12'h400));
    check("ctl3 idle", 16'h0000, word(1'b0, 12'h418));
    // a burst while the pointer is fetched aborts the next buffer empty
    slow <= 4'h6;
    put_desc(1, 16'h8000, 24'h000280);
    for (int i = 0; i < 1000; i++) begin
      @(posedge mclk);
      if (mem_ack === 1'b1 && mem_we === 1'b0 && mem_addr === 24'h00040C) break;
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data <= 8'h80 + 8'(i);
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    wait_back(1);
    check("ctl1 abort", 16'h0002, word(1'b0, 12'h408));
    check("len1 abort", 16'h0000, word(1'b0, 12'h40A));
    @(posedge mclk);
    reg_addr <= v110_rx_pkg::REG_STATE;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check("state flags", 16'h0182, reg_rdata & 16'hFFC7);
    tally_and_finish();
  end
endmodule : v110_rx_descriptor_ring_bench
`default_nettype wire
